// ---- als_regs.svh ----
// register offsets, field positions, reset values and timing counts of the light sequencer
`ifndef ALS_REGS_SVH
`define ALS_REGS_SVH
`define ALS_OFF_CTRL 8'h00
`define ALS_OFF_STATUS 8'h04
`define ALS_OFF_RESULT 8'h08
`define ALS_OFF_AVG 8'h0C
`define ALS_OFF_TICK 8'h10
`define ALS_CTRL_RUN 0
`define ALS_CTRL_TRIG 1
`define ALS_CTRL_REF_LSB 2
`define ALS_RES_LUX_LSB 16
`define ALS_AVG_REF_LSB 16
`define ALS_TICK_CNT_LSB 16
`define ALS_REF_SUPPLY 2'h0
`define ALS_REF_INTERNAL 2'h1
`define ALS_REF_EXTERNAL 2'h2
`define ALS_CH_SENSE 2'h0
`define ALS_CH_REF_HIGH 2'h2
`define ALS_CH_REF_LOW 2'h3
`define ALS_SW_PRESSED 1'b0
`define ALS_CLK_PERIOD_PS 8000
`define ALS_MS_PS 1000000000
`define ALS_MS_CYCLES (`ALS_MS_PS / `ALS_CLK_PERIOD_PS)
`define ALS_SETTLE_MS 5'h10
`define ALS_PERIOD_TICKS 10'h271
`define ALS_SAMPLES 3'h4
`define ALS_DIV_STEPS 5'h1A
`define ALS_FS_HIGH_LUX10 16'h4074
`define ALS_FS_LOW_LUX10 16'h0144
`define ALS_DUTY_FULL_LUX10 16'h01F4
`define ALS_DUTY_ZERO_LUX10 16'h1388
`define ALS_DUTY_SPAN_LUX10 16'h1194
`define ALS_DUTY_MAX 8'hFF
`define ALS_LOW_THRESH_LUX10 16'h0096
`define ALS_RST_REF_SEL 2'h0
`endif

// ---- als_pkg.sv ----
// types shared by the light sequencer
package als_pkg;
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_SETTLE = 6'h02,
        ST_CONV = 6'h04,
        ST_WAIT = 6'h08,
        ST_DIVL = 6'h10,
        ST_DIVD = 6'h20
    } als_state_t;
    typedef struct packed {
        logic run;
        logic [1:0] ref_sel;
    } als_ctrl_t;
    typedef struct packed {
        logic [16:0] rem;
        logic [25:0] quo;
    } als_div_t;
    typedef struct packed {
        logic sel;
        logic write;
        logic [7:0] addr;
    } als_aphase_t;
endpackage

// ---- als_light_seq.sv ----
// ambient light measurement sequencer with ahb-lite register access
//
// Our own choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
`include "als_regs.svh"
module als_light_seq #(
    parameter int MS_CYCLES = `ALS_MS_CYCLES
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic switch_input_pin,
    output logic adc_start,
    output logic [1:0] adc_channel,
    output logic [1:0] adc_ref_sel,
    input wire logic adc_done,
    input wire logic [9:0] adc_data,
    output logic low_range_sel,
    output logic high_range_sel,
    output logic [7:0] pwm_duty
);
    // one restoring division step: shift in the next dividend bit, subtract if it fits
    function automatic als_pkg::als_div_t div_step(als_pkg::als_div_t d, logic [15:0] den);
        logic [16:0] sh;
        als_pkg::als_div_t r;
        sh = {d.rem[15:0], d.quo[25]};
        r.quo = {d.quo[24:0], 1'b0};
        r.rem = sh;
        if (sh >= {1'b0, den}) begin
            r.rem = sh - {1'b0, den};
            r.quo[0] = 1'b1;
        end
        return r;
    endfunction

    // ---- time base
    logic [16:0] ms_div;
    logic [15:0] ms_count;
    logic ms_pulse;
    logic [16:0] next_ms_div;
    logic [15:0] next_ms_count;
    logic next_ms_pulse;
    logic sw_meta;
    logic sw_sync;

    always_comb begin
        next_ms_div = ms_div + 17'h00001;
        next_ms_count = ms_count;
        next_ms_pulse = 1'b0;
        if (ms_div == 17'(MS_CYCLES - 1)) begin
            next_ms_div = 17'h00000;
            next_ms_count = ms_count + 16'h0001;
            next_ms_pulse = 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ms_div <= 17'h00000;
            ms_count <= 16'h0000;
            ms_pulse <= 1'b0;
            sw_meta <= 1'b1;
            sw_sync <= 1'b1;
        end else begin
            ms_div <= next_ms_div;
            ms_count <= next_ms_count;
            ms_pulse <= next_ms_pulse;
            sw_meta <= switch_input_pin;
            sw_sync <= sw_meta;
        end
    end

    // ---- bus slave
    als_pkg::als_aphase_t aph;
    als_pkg::als_ctrl_t ctrl;
    logic trig_wr;
    als_pkg::als_aphase_t next_aph;
    als_pkg::als_ctrl_t next_ctrl;
    logic next_trig_wr;
    logic [31:0] next_hrdata;

    // sequencer state; state, flags, tick counts, averages and lux10 are read back by the bus
    als_pkg::als_state_t state;
    logic [11:0] tick_prev;
    logic [9:0] tick_counter;
    logic first_pending;
    logic trig_pending;
    logic range_low;
    logic [4:0] settle_cnt;
    logic [2:0] conv_idx;
    logic [11:0] sum_s;
    logic [11:0] sum_r;
    logic [9:0] avg_s;
    logic [9:0] avg_r;
    als_pkg::als_div_t div;
    logic [15:0] div_den;
    logic [4:0] div_cnt;
    logic [15:0] lux10;

    always_comb begin
        next_aph.sel = hsel & htrans[1] & hready;
        next_aph.write = hwrite;
        next_aph.addr = haddr[7:0];
        next_ctrl = ctrl;
        next_trig_wr = 1'b0;
        next_hrdata = hrdata;
        if (aph.sel && aph.write && aph.addr == `ALS_OFF_CTRL) begin
            next_ctrl.run = hwdata[`ALS_CTRL_RUN];
            next_trig_wr = hwdata[`ALS_CTRL_TRIG];
            if (hwdata[`ALS_CTRL_REF_LSB+1:`ALS_CTRL_REF_LSB] != 2'h3) begin
                next_ctrl.ref_sel = hwdata[`ALS_CTRL_REF_LSB+1:`ALS_CTRL_REF_LSB];
            end
        end
        if (next_aph.sel && !hwrite) begin
            case (haddr[7:0])
                `ALS_OFF_CTRL: next_hrdata = {28'h0000000, ctrl.ref_sel, 1'b0, ctrl.run};
                `ALS_OFF_STATUS: next_hrdata = {23'h000000, trig_pending, first_pending,
                    range_low, state};
                `ALS_OFF_RESULT: next_hrdata = {lux10, 8'h00, pwm_duty};
                `ALS_OFF_AVG: next_hrdata = {6'h00, avg_r, 6'h00, avg_s};
                `ALS_OFF_TICK: next_hrdata = {6'h00, tick_counter, 4'h0, tick_prev};
                default: next_hrdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            aph <= '0;
            ctrl <= '{run: 1'b0, ref_sel: `ALS_RST_REF_SEL};
            trig_wr <= 1'b0;
            hrdata <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            adc_ref_sel <= `ALS_RST_REF_SEL;
        end else begin
            aph <= next_aph;
            ctrl <= next_ctrl;
            trig_wr <= next_trig_wr;
            hrdata <= next_hrdata;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            adc_ref_sel <= next_ctrl.ref_sel;
        end
    end

    // ---- measurement sequencer
    als_pkg::als_state_t next_state;
    logic [11:0] next_tick_prev;
    logic [9:0] next_tick_counter;
    logic next_first_pending;
    logic next_trig_pending;
    logic next_range_low;
    logic [4:0] next_settle_cnt;
    logic [2:0] next_conv_idx;
    logic [11:0] next_sum_s;
    logic [11:0] next_sum_r;
    logic [9:0] next_avg_s;
    logic [9:0] next_avg_r;
    als_pkg::als_div_t next_div;
    logic [15:0] next_div_den;
    logic [4:0] next_div_cnt;
    logic [15:0] next_lux10;
    logic [7:0] next_pwm_duty;
    logic next_adc_start;
    logic [1:0] next_adc_channel;
    logic next_low_sel;
    logic next_high_sel;
    logic [11:0] tick_now;
    logic [9:0] cnt_inc;
    logic start;
    logic [15:0] fs;
    logic [15:0] lux_sat;

    always_comb begin
        next_state = state;
        next_tick_prev = tick_prev;
        next_tick_counter = tick_counter;
        next_first_pending = first_pending;
        next_trig_pending = trig_pending | trig_wr;
        next_range_low = range_low;
        next_settle_cnt = settle_cnt;
        next_conv_idx = conv_idx;
        next_sum_s = sum_s;
        next_sum_r = sum_r;
        next_avg_s = avg_s;
        next_avg_r = avg_r;
        next_div = div;
        next_div_den = div_den;
        next_div_cnt = div_cnt;
        next_lux10 = lux10;
        next_pwm_duty = pwm_duty;
        next_adc_start = 1'b0;
        next_adc_channel = adc_channel;
        next_low_sel = low_range_sel;
        next_high_sel = high_range_sel;
        tick_now = ms_count[15:4];
        cnt_inc = tick_counter + 10'h001;
        start = 1'b0;
        fs = range_low ? `ALS_FS_LOW_LUX10 : `ALS_FS_HIGH_LUX10;
        lux_sat = (div.quo[25:16] != 10'h000) ? 16'hFFFF : div.quo[15:0];
        case (state)
            als_pkg::ST_IDLE: begin
                if (ctrl.run) begin
                    if (first_pending) begin
                        start = 1'b1;
                    end else if (tick_now != tick_prev) begin
                        next_tick_prev = tick_now;
                        next_tick_counter = cnt_inc;
                        if (sw_sync == `ALS_SW_PRESSED || trig_pending
                            || cnt_inc >= `ALS_PERIOD_TICKS) begin
                            start = 1'b1;
                        end
                    end
                end
                if (start) begin
                    next_first_pending = 1'b0;
                    next_trig_pending = trig_wr;
                    next_tick_counter = 10'h000;
                    next_low_sel = range_low;
                    next_high_sel = ~range_low;
                    next_settle_cnt = 5'h00;
                    next_state = als_pkg::ST_SETTLE;
                end
            end
            als_pkg::ST_SETTLE: begin
                if (ms_pulse) begin
                    next_settle_cnt = settle_cnt + 5'h01;
                    if (next_settle_cnt == `ALS_SETTLE_MS) begin
                        next_conv_idx = 3'h0;
                        next_sum_s = 12'h000;
                        next_sum_r = 12'h000;
                        next_state = als_pkg::ST_CONV;
                    end
                end
            end
            als_pkg::ST_CONV: begin
                next_adc_start = 1'b1;
                if (!conv_idx[2]) begin
                    next_adc_channel = `ALS_CH_SENSE;
                end else begin
                    next_adc_channel = range_low ? `ALS_CH_REF_LOW : `ALS_CH_REF_HIGH;
                end
                next_state = als_pkg::ST_WAIT;
            end
            als_pkg::ST_WAIT: begin
                if (adc_done) begin
                    if (!conv_idx[2]) begin
                        next_sum_s = sum_s + {2'h0, adc_data};
                    end else begin
                        next_sum_r = sum_r + {2'h0, adc_data};
                    end
                    next_conv_idx = conv_idx + 3'h1;
                    next_state = als_pkg::ST_CONV;
                    if (conv_idx == 3'h7) begin
                        next_avg_s = next_sum_s[11:2];
                        next_avg_r = next_sum_r[11:2];
                        next_low_sel = 1'b0;
                        next_high_sel = 1'b0;
                        next_div.rem = 17'h00000;
                        next_div.quo = 26'(next_avg_s * fs);
                        next_div_den = {6'h00, next_avg_r};
                        next_div_cnt = `ALS_DIV_STEPS;
                        next_state = als_pkg::ST_DIVL;
                    end
                end
            end
            als_pkg::ST_DIVL: begin
                if (div_cnt != 5'h00) begin
                    next_div = div_step(div, div_den);
                    next_div_cnt = div_cnt - 5'h01;
                end else begin
                    next_lux10 = lux_sat;
                    next_range_low = lux_sat < `ALS_LOW_THRESH_LUX10;
                    next_state = als_pkg::ST_IDLE;
                    if (lux_sat <= `ALS_DUTY_FULL_LUX10) begin
                        next_pwm_duty = `ALS_DUTY_MAX;
                    end else if (lux_sat >= `ALS_DUTY_ZERO_LUX10) begin
                        next_pwm_duty = 8'h00;
                    end else begin
                        next_div.rem = 17'h00000;
                        next_div.quo = 26'((lux_sat - `ALS_DUTY_FULL_LUX10) * `ALS_DUTY_MAX);
                        next_div_den = `ALS_DUTY_SPAN_LUX10;
                        next_div_cnt = `ALS_DIV_STEPS;
                        next_state = als_pkg::ST_DIVD;
                    end
                end
            end
            als_pkg::ST_DIVD: begin
                if (div_cnt != 5'h00) begin
                    next_div = div_step(div, div_den);
                    next_div_cnt = div_cnt - 5'h01;
                end else begin
                    next_pwm_duty = `ALS_DUTY_MAX - div.quo[7:0];
                    next_state = als_pkg::ST_IDLE;
                end
            end
            default: next_state = als_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= als_pkg::ST_IDLE;
            tick_prev <= 12'h000;
            tick_counter <= 10'h000;
            first_pending <= 1'b1;
            trig_pending <= 1'b0;
            range_low <= 1'b0;
            settle_cnt <= 5'h00;
            conv_idx <= 3'h0;
            sum_s <= 12'h000;
            sum_r <= 12'h000;
            avg_s <= 10'h000;
            avg_r <= 10'h000;
            div <= '0;
            div_den <= 16'h0000;
            div_cnt <= 5'h00;
            lux10 <= 16'h0000;
            pwm_duty <= 8'h00;
            adc_start <= 1'b0;
            adc_channel <= `ALS_CH_SENSE;
            low_range_sel <= 1'b0;
            high_range_sel <= 1'b0;
        end else begin
            state <= next_state;
            tick_prev <= next_tick_prev;
            tick_counter <= next_tick_counter;
            first_pending <= next_first_pending;
            trig_pending <= next_trig_pending;
            range_low <= next_range_low;
            settle_cnt <= next_settle_cnt;
            conv_idx <= next_conv_idx;
            sum_s <= next_sum_s;
            sum_r <= next_sum_r;
            avg_s <= next_avg_s;
            avg_r <= next_avg_r;
            div <= next_div;
            div_den <= next_div_den;
            div_cnt <= next_div_cnt;
            lux10 <= next_lux10;
            pwm_duty <= next_pwm_duty;
            adc_start <= next_adc_start;
            adc_channel <= next_adc_channel;
            low_range_sel <= next_low_sel;
            high_range_sel <= next_high_sel;
        end
    end
endmodule

// ---- als_light_seq_assertions.sv ----
// port-level checks for the light sequencer
`timescale 1ns/100ps
module als_light_seq_assertions #(
    parameter int MS_CYCLES = 8
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic adc_start,
    input wire logic [1:0] adc_channel,
    input wire logic [1:0] adc_ref_sel,
    input wire logic adc_done,
    input wire logic low_range_sel,
    input wire logic high_range_sel,
    input wire logic [7:0] pwm_duty
);
    localparam int SET_LO = 14 * MS_CYCLES;
    localparam int SET_HI = 17 * MS_CYCLES;
    logic wr_q;
    logic rd_q;
    logic [1:0] ref_q;
    logic [3:0] n_start;
    logic [3:0] n_done;
    int settle;
    wire logic load_on = low_range_sel | high_range_sel;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // count starts and answers of the current load window
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            ref_q <= 2'h0;
            n_start <= 4'h0;
            n_done <= 4'h0;
            settle <= 0;
        end else begin
            wr_q <= hsel & htrans[1] & hready & hwrite & (haddr[7:0] == 8'h00);
            rd_q <= hsel & htrans[1] & hready & !hwrite & (haddr[7:0] == 8'h08);
            ref_q <= hwdata[3:2];
            n_start <= load_on ? n_start + {3'h0, adc_start} : 4'h0;
            n_done <= load_on ? n_done + {3'h0, adc_done} : 4'h0;
            settle <= (load_on && n_start == 4'h0) ? settle + 1 : 0;
        end
    end
    ref_write_a: assert property (wr_q && hwdata[3:2] != 2'h3 |=> adc_ref_sel == ref_q)
        else $error("reference select did not follow the control write");
    ref_legal_a: assert property (adc_ref_sel != 2'h3)
        else $error("reference select took the reserved code");
    duty_read_a: assert property (rd_q && $stable(pwm_duty) |->
        hrdata[7:0] == pwm_duty)
        else $error("result read differs from the duty output");
    settle_time_a: assert property (adc_start && n_start == 4'h0 |->
        settle >= SET_LO && settle <= SET_HI)
        else $error("first conversion outside the settle window");
    start_load_a: assert property (adc_start |-> load_on)
        else $error("conversion started without a load");
    chan_order_a: assert property (adc_start |-> (adc_channel == 2'h0) == (n_start < 4'h4))
        else $error("conversion channel order wrong");
    drive_chan_a: assert property (adc_start && n_start >= 4'h4 |->
        adc_channel == (low_range_sel ? 2'h3 : 2'h2))
        else $error("drive channel does not match the load");
    load_release_a: assert property (adc_done && n_done == 4'h7 |=> !load_on)
        else $error("load kept after the eighth answer");
    load_count_a: assert property ($fell(load_on) |-> n_done == 4'h8)
        else $error("load released before eight answers");
    start_pulse_a: assert property (adc_start |=> !adc_start)
        else $error("conversion start longer than one cycle");
    load_excl_a: assert property (!(low_range_sel && high_range_sel))
        else $error("both loads selected");
    duty_quiet_a: assert property ($changed(pwm_duty) |-> !load_on)
        else $error("duty changed while sampling");
    low_meas_c: cover property (adc_start && low_range_sel);
    duty_new_c: cover property ($changed(pwm_duty));
    duty_rd_c: cover property (rd_q);
endmodule
bind als_light_seq als_light_seq_assertions #(.MS_CYCLES(MS_CYCLES)) u_chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .adc_start(adc_start), .adc_channel(adc_channel), .adc_ref_sel(adc_ref_sel),
    .adc_done(adc_done), .low_range_sel(low_range_sel), .high_range_sel(high_range_sel),
    .pwm_duty(pwm_duty));

// ---- als_adc_model.sv ----
// converter model: answers each start with base plus a per-sample step
`timescale 1ns/100ps
module als_adc_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic adc_start,
    input wire logic [1:0] adc_channel,
    input wire logic [9:0] sense_base,
    input wire logic [9:0] drive_base,
    input wire logic slow,
    output logic adc_done,
    output logic [9:0] adc_data
);
    logic busy;
    logic [1:0] idx;
    logic [1:0] ch;
    logic [4:0] cnt;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            busy <= 1'b0;
            idx <= 2'h0;
            ch <= 2'h0;
            cnt <= 5'h0;
            adc_done <= 1'b0;
            adc_data <= 10'h155;
        end else begin
            adc_done <= 1'b0;
            if (adc_start) begin
                busy <= 1'b1;
                ch <= adc_channel;
                cnt <= slow ? 5'h14 : 5'h01;
            end else if (busy && cnt != 5'h0) begin
                cnt <= cnt - 5'h01;
            end else if (busy) begin
                busy <= 1'b0;
                adc_done <= 1'b1;
                idx <= idx + 2'h1;
                adc_data <= (ch == 2'h0 ? sense_base : drive_base) + {8'h00, idx};
            end else begin
                // stale data must not look valid
                adc_data <= ~adc_data;
            end
        end
    end
endmodule

// ---- test_ambient_light_pwm_sequencer.sv ----
// self-checking bench for the light sequencer
`timescale 1ns/100ps
module test_ambient_light_pwm_sequencer;
    localparam int MS = 4;
    localparam int TICK = 16 * MS;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hready;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic switch_input_pin = 1'b1;
    logic adc_start;
    logic [1:0] adc_channel;
    logic [1:0] adc_ref_sel;
    logic adc_done;
    logic [9:0] adc_data;
    logic low_range_sel;
    logic high_range_sel;
    logic [7:0] pwm_duty;
    logic [9:0] sense_base = 10'h0;
    logic [9:0] drive_base = 10'h0;
    logic slow = 1'b0;
    logic exp_low = 1'b0;
    int err_total = 0;
    int total_checks = 0;
    int cyc = 0;
    int t_on = 0;
    int s_tab[6] = '{9, 99, 499, 0, 1019, 9};
    int r_tab[6] = '{999, 999, 999, 999, 99, 999};
    int m_tab[6] = '{0, 1, 2, 1, 2, 3};
    assign hready = hreadyout;
    always #4 hclk = ~hclk;
    always @(posedge hclk) cyc <= cyc + 1;
    als_light_seq #(.MS_CYCLES(MS)) dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .switch_input_pin(switch_input_pin), .adc_start(adc_start),
        .adc_channel(adc_channel), .adc_ref_sel(adc_ref_sel), .adc_done(adc_done),
        .adc_data(adc_data), .low_range_sel(low_range_sel),
        .high_range_sel(high_range_sel), .pwm_duty(pwm_duty));
    als_adc_model model (
        .hclk(hclk), .hresetn(hresetn), .adc_start(adc_start), .adc_channel(adc_channel),
        .sense_base(sense_base), .drive_base(drive_base), .slow(slow),
        .adc_done(adc_done), .adc_data(adc_data));
    task automatic complete_run();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        hsize <= 3'h2;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] x;
        bus(1'b0, a, 32'h0, x);
        chk(x, exp);
        chk({31'h0, hresp}, 32'h0);
    endtask
    function automatic logic [15:0] lux_of(input int s, input int r, input logic low);
        int v;
        v = (s + 1) * (low ? 324 : 16500) / (r + 1);
        return v > 65535 ? 16'hFFFF : v[15:0];
    endfunction
    function automatic logic [7:0] duty_of(input int l);
        if (l <= 500)
            return 8'hFF;
        if (l >= 5000)
            return 8'h00;
        return 8'(255 - (l - 500) * 255 / 4500);
    endfunction
    task automatic run_case(input int i);
        int g;
        logic [31:0] x;
        logic [15:0] lux;
        logic [7:0] d;
        sense_base <= s_tab[i][9:0];
        drive_base <= r_tab[i][9:0];
        slow <= i[0];
        if (m_tab[i] == 0)
            wr(8'h00, 32'h9);
        if (m_tab[i] == 1)
            wr(8'h00, 32'hB);
        if (m_tab[i] == 2)
            switch_input_pin <= 1'b0;
        while (!(low_range_sel | high_range_sel)) @(posedge hclk);
        switch_input_pin <= 1'b1;
        g = cyc - t_on;
        t_on = cyc;
        chk(low_range_sel, exp_low);
        chk(high_range_sel, !exp_low);
        if (m_tab[i] == 3)
            chk(g >= 624 * TICK && g <= 628 * TICK, 1);
        x = 32'h0;
        while (x[5:0] !== 6'h01) bus(1'b0, 8'h04, 32'h0, x);
        lux = lux_of(s_tab[i], r_tab[i], exp_low);
        d = duty_of(lux);
        chk(pwm_duty, d);
        rdc(8'h08, {lux, 8'h00, d});
        rdc(8'h0C, {6'h0, r_tab[i][9:0] + 10'h1, 6'h0, s_tab[i][9:0] + 10'h1});
        exp_low = lux < 16'h0096;
    endtask
    initial begin
        repeat (100000) @(posedge hclk);
        err_total++;
        complete_run();
    end
    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk({pwm_duty, low_range_sel, high_range_sel}, 0);
        rdc(8'h00, 32'h0);
        wr(8'h14, 32'hFFFFFFFF);
        rdc(8'h14, 32'h0);
        for (int i = 0; i < 4; i++) begin
            wr(8'h00, i << 2);
            @(posedge hclk);
            chk(adc_ref_sel, i == 3 ? 2 : i);
        end
        rdc(8'h00, 32'h8);
        for (int i = 0; i < 6; i++) run_case(i);
        complete_run();
    end
endmodule
